// ### src/prc_consts.svh
// constants for the power and reference control register bank
`ifndef PRC_CONSTS_SVH
`define PRC_CONSTS_SVH
// widths: address, stored data, read data, revision
`define PRC_AW 7
`define PRC_DW 9
`define PRC_RW 16
`define PRC_REV_W 3
`define PRC_NREG 9
// register addresses
`define PRC_ADDR_RESET 7'h00
`define PRC_ADDR_PWR1 7'h01
`define PRC_ADDR_PWR2 7'h02
`define PRC_ADDR_PWR3 7'h03
`define PRC_ADDR_FMT 7'h04
`define PRC_ADDR_COMP 7'h05
`define PRC_ADDR_CLK 7'h06
`define PRC_ADDR_EXTRA 7'h07
`define PRC_ADDR_GPIO 7'h08
`define PRC_ADDR_OUT 7'h31
// storage slot of each register
`define PRC_IDX_PWR1 0
`define PRC_IDX_PWR2 1
`define PRC_IDX_PWR3 2
`define PRC_IDX_FMT 3
`define PRC_IDX_COMP 4
`define PRC_IDX_CLK 5
`define PRC_IDX_EXTRA 6
`define PRC_IDX_GPIO 7
`define PRC_IDX_OUT 8
// writable bits, fixed-zero bits are clear
`define PRC_MASK_PWR1 9'h0fb
`define PRC_MASK_PWR2 9'h015
`define PRC_MASK_PWR3 9'h000
`define PRC_MASK_FMT 9'h1fa
`define PRC_MASK_COMP 9'h026
`define PRC_MASK_CLK 9'h1fd
`define PRC_MASK_EXTRA 9'h03f
`define PRC_MASK_GPIO 9'h0bf
`define PRC_MASK_OUT 9'h002
// reset values
`define PRC_RST_PWR1 9'h000
`define PRC_RST_PWR2 9'h000
`define PRC_RST_PWR3 9'h000
`define PRC_RST_FMT 9'h050
`define PRC_RST_COMP 9'h000
`define PRC_RST_CLK 9'h140
`define PRC_RST_EXTRA 9'h000
`define PRC_RST_GPIO 9'h000
`define PRC_RST_OUT 9'h002
// field positions
`define PRC_REF_SEL_LSB 0
`define PRC_REF_SEL_W 2
`define PRC_BIAS_BIT 3
`define PRC_DISCHARGE_BIT 4
`define PRC_SOFTSTART_BIT 5
`define PRC_OVERTEMP_BIT 1
// reference string impedance codes
`define PRC_REF_OFF 2'h0
`define PRC_REF_50K 2'h1
`define PRC_REF_250K 2'h2
`define PRC_REF_5K 2'h3
`endif

// ### src/prc_pkg.sv
// types for the power and reference control register bank
`default_nettype none
`include "prc_consts.svh"
package prc_pkg;
    // reference string impedance selection
    typedef enum logic [`PRC_REF_SEL_W-1:0] {
        ref_off  = `PRC_REF_OFF,
        ref_50k  = `PRC_REF_50K,
        ref_250k = `PRC_REF_250K,
        ref_5k   = `PRC_REF_5K
    } prc_ref_imp_t;
    // one register command from the control port
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [`PRC_AW-1:0]  addr;
        logic [`PRC_DW-1:0]  wdata;
    } prc_cmd_t;
    // read answer
    typedef struct packed {
        logic [`PRC_RW-1:0]  data;
        logic                valid;
    } prc_rsp_t;
    // control outputs to the analogue and digital sections
    typedef struct packed {
        prc_ref_imp_t                          ref_string_impedance_sel;
        logic                                  amp_bias_enable;
        logic                                  ref_softstart_enable;
        logic                                  ref_fast_discharge;
        logic                                  overtemp_protect_enable;
        logic [`PRC_NREG-1:0][`PRC_DW-1:0]     words;
    } prc_ctrl_t;
    // state of one stored register
    typedef struct packed {
        logic [`PRC_DW-1:0]  value;
    } prc_reg_state_t;
    // state of the bank outside the stored registers
    typedef struct packed {
        prc_rsp_t            rsp;
        logic                rst_pulse;
        logic [1:0]          hot_sync;
        logic                alarm;
    } prc_top_state_t;
endpackage
`default_nettype wire

// ### src/prc_wreg.sv
// one masked control register with power-on and software reset
`timescale 1ns/1ps
`default_nettype none
`include "prc_consts.svh"
module prc_wreg #(
    parameter logic [`PRC_DW-1:0] MASK = 9'h1ff,
    parameter logic [`PRC_DW-1:0] RST  = 9'h000
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    // write side
    input  wire logic               wr_en,
    input  wire logic               soft_rst,
    input  wire logic [`PRC_DW-1:0] wdata,
    // stored value
    output var  logic [`PRC_DW-1:0] value
);
    prc_pkg::prc_reg_state_t st_ff;
    prc_pkg::prc_reg_state_t nxt_st;

    // a reset value outside the writable bits could never be written back
    if ((RST & ~MASK) != '0)
    begin : g_bad_rst
        $error("reset value sets a fixed-zero bit");
    end

    // software reset beats a write, fixed-zero bits never store
    always_comb
    begin
        nxt_st = st_ff;
        if (soft_rst)
            nxt_st.value = RST;
        else if (wr_en)
            nxt_st.value = wdata & MASK;
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '{value: RST};
        else if (ce)
            st_ff <= nxt_st;
    end

    assign value = st_ff.value;
endmodule
`default_nettype wire

// ### src/prc_regs.sv
// power and reference control register bank with identification readback
`timescale 1ns/1ps
`default_nettype none
`include "prc_consts.svh"
// Overview of operation
// - reference impedance select resets off, four codes
// - bit 3 enables amplifier bias, resets zero
// - bit 5 enables reference soft start
// - bit 4 enables fast reference discharge
// - overtemperature protect enable resets to one
// - write to address zero resets all registers
// - read of address zero returns part identifier
module prc_regs #(
    parameter logic [`PRC_RW-1:0]    PART_ID    = 16'h5a3c, // arbitrary value
    parameter logic [`PRC_REV_W-1:0] DEVICE_REV = 3'h1      // arbitrary value
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    // register command port
    input  wire prc_pkg::prc_cmd_t  cmd,
    output var  prc_pkg::prc_rsp_t  rsp,
    // analogue side
    input  wire logic               die_hot_async,
    output var  prc_pkg::prc_ctrl_t ctrl,
    output var  logic               sw_reset_pulse,
    output var  logic               overtemp_alarm
);
    // address, writable mask and reset value of each stored register
    localparam logic [`PRC_AW-1:0] ADDR_TAB [`PRC_NREG] = '{
        `PRC_ADDR_PWR1, `PRC_ADDR_PWR2, `PRC_ADDR_PWR3, `PRC_ADDR_FMT, `PRC_ADDR_COMP,
        `PRC_ADDR_CLK, `PRC_ADDR_EXTRA, `PRC_ADDR_GPIO, `PRC_ADDR_OUT};
    localparam logic [`PRC_DW-1:0] MASK_TAB [`PRC_NREG] = '{
        `PRC_MASK_PWR1, `PRC_MASK_PWR2, `PRC_MASK_PWR3, `PRC_MASK_FMT, `PRC_MASK_COMP,
        `PRC_MASK_CLK, `PRC_MASK_EXTRA, `PRC_MASK_GPIO, `PRC_MASK_OUT};
    localparam logic [`PRC_DW-1:0] RST_TAB [`PRC_NREG] = '{
        `PRC_RST_PWR1, `PRC_RST_PWR2, `PRC_RST_PWR3, `PRC_RST_FMT, `PRC_RST_COMP,
        `PRC_RST_CLK, `PRC_RST_EXTRA, `PRC_RST_GPIO, `PRC_RST_OUT};

    prc_pkg::prc_top_state_t          st_ff;
    prc_pkg::prc_top_state_t          nxt_st;
    logic [`PRC_NREG-1:0][`PRC_DW-1:0] words;
    logic [`PRC_NREG-1:0]             wr_hit;
    logic                             sw_rst;
    logic [`PRC_RW-1:0]               rd_word;

    // the revision field must fit under the bias bit above it
    if (`PRC_REV_W > `PRC_BIAS_BIT)
    begin : g_bad_rev
        $error("revision field overlaps writable bits");
    end

    // every single-bit control field must lie in the writable bits of its word
    if (!MASK_TAB[`PRC_IDX_OUT][`PRC_OVERTEMP_BIT] || !MASK_TAB[`PRC_IDX_PWR1][`PRC_BIAS_BIT]
        || !MASK_TAB[`PRC_IDX_EXTRA][`PRC_SOFTSTART_BIT] || !MASK_TAB[`PRC_IDX_EXTRA][`PRC_DISCHARGE_BIT])
    begin : g_bad_mask
        $error("control field in a fixed-zero bit");
    end

    // any write to address zero is a software reset, data ignored
    assign sw_rst = cmd.wr && (cmd.addr == `PRC_ADDR_RESET);

    // one masked register per mapped address
    for (genvar i = 0; i < `PRC_NREG; i++)
    begin : g_reg
        assign wr_hit[i] = cmd.wr && (cmd.addr == ADDR_TAB[i]);
        prc_wreg #(
            .MASK (MASK_TAB[i]),
            .RST  (RST_TAB[i])
        ) u_reg (
            .clk      (clk),
            .nrst     (nrst),
            .ce       (ce),
            .wr_en    (wr_hit[i]),
            .soft_rst (sw_rst),
            .wdata    (cmd.wdata),
            .value    (words[i])
        );
    end

    // read data select: identifier at zero, revision in the low bits of
    // power control one, stored words elsewhere, zero when unmapped
    always_comb
    begin
        rd_word = '0;
        if (cmd.addr == `PRC_ADDR_RESET)
            rd_word = PART_ID;
        else
        begin
            for (int j = 0; j < `PRC_NREG; j++)
            begin
                if (cmd.addr == ADDR_TAB[j])
                    rd_word = {{(`PRC_RW - `PRC_DW){1'b0}}, words[j]};
            end
            if (cmd.addr == `PRC_ADDR_PWR1)
                rd_word[`PRC_REV_W-1:0] = DEVICE_REV;
        end
    end

    // next state: read answer, reset pulse, overtemperature synchroniser
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rsp.valid = cmd.rd;
        if (cmd.rd)
            nxt_st.rsp.data = rd_word;
        nxt_st.rst_pulse = sw_rst;
        nxt_st.hot_sync = {st_ff.hot_sync[0], die_hot_async};
        // alarm only while protection is enabled
        nxt_st.alarm = st_ff.hot_sync[1] && words[`PRC_IDX_OUT][`PRC_OVERTEMP_BIT];
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    // outputs straight from the state and register flops
    always_comb
    begin
        ctrl = '0;
        ctrl.words = words;
        ctrl.ref_string_impedance_sel = prc_pkg::prc_ref_imp_t'(
            words[`PRC_IDX_PWR1][`PRC_REF_SEL_LSB +: `PRC_REF_SEL_W]);
        ctrl.amp_bias_enable = words[`PRC_IDX_PWR1][`PRC_BIAS_BIT];
        ctrl.ref_softstart_enable = words[`PRC_IDX_EXTRA][`PRC_SOFTSTART_BIT];
        // host must keep this low outside power-down
        ctrl.ref_fast_discharge = words[`PRC_IDX_EXTRA][`PRC_DISCHARGE_BIT];
        ctrl.overtemp_protect_enable = words[`PRC_IDX_OUT][`PRC_OVERTEMP_BIT];
    end

    assign rsp            = st_ff.rsp;
    assign sw_reset_pulse = st_ff.rst_pulse;
    assign overtemp_alarm = st_ff.alarm;

    // checks on the bank, all in the clk domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // a taken write to a given address
    sequence s_wr(logic [`PRC_AW-1:0] a);
        ce && cmd.wr && (cmd.addr == a);
    endsequence

    // a taken software reset
    sequence s_sw_rst;
        ce && cmd.wr && (cmd.addr == `PRC_ADDR_RESET);
    endsequence

    // impedance select follows a write and returns to off after software reset
    property p_ref_sel;
        logic [1:0] d;
        (s_wr(`PRC_ADDR_PWR1), d = cmd.wdata[1:0])
            |=> (ctrl.ref_string_impedance_sel == prc_pkg::prc_ref_imp_t'(d));
    endproperty
    a_ref_sel : assert property (p_ref_sel) else $error("impedance select not written");

    property p_ref_off;
        s_sw_rst |=> (ctrl.ref_string_impedance_sel == prc_pkg::ref_off);
    endproperty
    a_ref_off : assert property (p_ref_off) else $error("impedance select not off after reset");

    // bias enable takes bit 3 of the written word
    property p_bias;
        logic b;
        (s_wr(`PRC_ADDR_PWR1), b = cmd.wdata[3]) |=> (ctrl.amp_bias_enable == b);
    endproperty
    a_bias : assert property (p_bias) else $error("bias enable not bit 3");

    // soft start takes bit 5 and holds one more cycle unless a write or reset comes
    property p_softstart;
        logic b;
        (s_wr(`PRC_ADDR_EXTRA), b = cmd.wdata[5]) |=> (ctrl.ref_softstart_enable == b)
            ##1 ((ctrl.ref_softstart_enable == b) || $past(sw_rst) || $past(wr_hit[6]));
    endproperty
    a_softstart : assert property (p_softstart) else $error("soft start not bit 5");

    // fast discharge takes bit 4
    property p_discharge;
        logic b;
        (s_wr(`PRC_ADDR_EXTRA), b = cmd.wdata[4]) |=> (ctrl.ref_fast_discharge == b);
    endproperty
    a_discharge : assert property (p_discharge) else $error("fast discharge not bit 4");

    // protection comes back enabled after a software reset
    property p_tsd_rst;
        s_sw_rst |=> ctrl.overtemp_protect_enable;
    endproperty
    a_tsd_rst : assert property (p_tsd_rst) else $error("protection not enabled after reset");

    // an alarm needs the enable and a synchronised hot level one cycle before
    property p_alarm;
        $rose(overtemp_alarm) |-> $past(ctrl.overtemp_protect_enable) && $past(st_ff.hot_sync[1]);
    endproperty
    a_alarm : assert property (p_alarm) else $error("alarm without enable");

    // format, clock, power control one, extra and output words hold their defaults after a software reset, with the pulse raised
    property p_all_default;
        s_sw_rst |=> (words[`PRC_IDX_FMT] == `PRC_RST_FMT) && (words[`PRC_IDX_CLK] == `PRC_RST_CLK)
            && (words[`PRC_IDX_PWR1] == '0) && (words[`PRC_IDX_EXTRA] == '0)
            && (words[`PRC_IDX_OUT] == `PRC_RST_OUT) && sw_reset_pulse;
    endproperty
    a_all_default : assert property (p_all_default) else $error("register not at default");

    // reading address zero gives the identifier, marked valid, one cycle later
    property p_ident;
        (ce && cmd.rd && (cmd.addr == `PRC_ADDR_RESET)) |=> rsp.valid && (rsp.data == PART_ID);
    endproperty
    a_ident : assert property (p_ident) else $error("identifier not returned");

    // power control one, three and clock words store no fixed-zero bit; reads but of address zero clear bits 15..9
    property p_fixed_zero;
        ((words[`PRC_IDX_PWR1] & ~`PRC_MASK_PWR1) == '0) && (words[`PRC_IDX_PWR3] == '0)
            && ((words[`PRC_IDX_CLK] & ~`PRC_MASK_CLK) == '0)
            && (!rsp.valid || $past(cmd.addr) == `PRC_ADDR_RESET || rsp.data[`PRC_RW-1:`PRC_DW] == '0);
    endproperty
    a_fixed_zero : assert property (p_fixed_zero) else $error("fixed-zero bit set");

    // a read answer lasts one cycle unless another read follows
    property p_rsp_pulse;
        (ce && !cmd.rd) |=> !rsp.valid;
    endproperty
    a_rsp_pulse : assert property (p_rsp_pulse) else $error("read answer too long");

    // read data holds until the next taken read
    property p_rsp_hold;
        (ce && !cmd.rd) |=> $stable(rsp.data);
    endproperty
    a_rsp_hold : assert property (p_rsp_hold) else $error("read data changed without a read");

    // every taken read is answered on the next edge
    property p_rd_answer;
        (ce && cmd.rd) |=> rsp.valid;
    endproperty
    a_rd_answer : assert property (p_rd_answer) else $error("read not answered");

    // power control one reads back the bias bit above the revision
    property p_pwr1_read;
        (ce && cmd.rd && (cmd.addr == `PRC_ADDR_PWR1))
            |=> (rsp.data[`PRC_REV_W-1:0] == DEVICE_REV)
            && (rsp.data[`PRC_BIAS_BIT] == $past(ctrl.amp_bias_enable));
    endproperty
    a_pwr1_read : assert property (p_pwr1_read) else $error("power control one readback wrong");

    // bias, soft start and discharge all come back clear after a software reset
    property p_bias_rst;
        s_sw_rst |=> !ctrl.amp_bias_enable;
    endproperty
    a_bias_rst : assert property (p_bias_rst) else $error("bias enabled after reset");

    property p_softstart_rst;
        s_sw_rst |=> !ctrl.ref_softstart_enable;
    endproperty
    a_softstart_rst : assert property (p_softstart_rst) else $error("soft start set after reset");

    property p_discharge_rst;
        s_sw_rst |=> !ctrl.ref_fast_discharge;
    endproperty
    a_discharge_rst : assert property (p_discharge_rst) else $error("fast discharge set after reset");

    // protection enable takes bit 1 of the output control word
    property p_tsd_wr;
        logic b;
        (s_wr(`PRC_ADDR_OUT), b = cmd.wdata[`PRC_OVERTEMP_BIT]) |=> (ctrl.overtemp_protect_enable == b);
    endproperty
    a_tsd_wr : assert property (p_tsd_wr) else $error("protection enable not bit 1");

    // a synchronised hot level while protection is enabled
    sequence s_hot_armed;
        ce && st_ff.hot_sync[1] && ctrl.overtemp_protect_enable;
    endsequence

    property p_alarm_on;
        s_hot_armed |=> overtemp_alarm;
    endproperty
    a_alarm_on : assert property (p_alarm_on) else $error("alarm missing while hot");

    // with protection disabled the alarm is down after one edge
    property p_alarm_off;
        (ce && !ctrl.overtemp_protect_enable) |=> !overtemp_alarm;
    endproperty
    a_alarm_off : assert property (p_alarm_off) else $error("alarm while protection disabled");

    // the reset pulse follows only a taken write to address zero
    property p_rst_pulse_src;
        (ce && !sw_rst) |=> !sw_reset_pulse;
    endproperty
    a_rst_pulse_src : assert property (p_rst_pulse_src) else $error("reset pulse without a reset write");

    // the all-zero power control word always reads back zero
    property p_pwr3_read;
        (ce && cmd.rd && (cmd.addr == `PRC_ADDR_PWR3)) |=> (rsp.data == '0);
    endproperty
    a_pwr3_read : assert property (p_pwr3_read) else $error("fixed-zero word reads nonzero");
endmodule
`default_nettype wire

// ### verif/prc_host.sv
// host model driving the register command port of the control bank
`timescale 1ns/1ps
`default_nettype none
module prc_host (
    // clock
    input  wire logic              clk,
    // command side
    output var  logic              ce,
    output var  prc_pkg::prc_cmd_t cmd,
    input  wire prc_pkg::prc_rsp_t rsp
);
    // idle port; discharge is left clear unless a power-down is ordered
    initial
    begin
        ce  = 1'b1;
        cmd = '0;
    end

    // one write, held until its taking edge, optionally with ce low
    task automatic wr(input logic [6:0] a, input logic [8:0] d, input logic e = 1'b1);
        @(posedge clk);
        ce  <= e;
        cmd <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        ce     <= 1'b1;
        cmd.wr <= 1'b0;
        #1;
    endtask

    // one read; answer must stand valid in the cycle after the taking edge
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        cmd <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 9'h000};
        @(posedge clk);
        cmd.rd <= 1'b0;
        #1;
        d = (rsp.valid === 1'b1) ? rsp.data : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the power and reference control bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // design and bench signals
    logic               clk;
    logic               nrst;
    logic               die_hot_async;
    logic               ce;
    prc_pkg::prc_cmd_t  cmd;
    prc_pkg::prc_rsp_t  rsp;
    prc_pkg::prc_ctrl_t ctrl;
    logic               sw_reset_pulse;
    logic               overtemp_alarm;
    int                 err_total;
    int                 n_compared;
    logic [15:0]        rv;
    localparam logic [15:0] ID  = 16'h2b7e; // arbitrary value
    localparam logic [2:0]  REV = 3'h5;     // arbitrary value
    logic [8:0]         dflt [9] = '{9'h000, 9'h000, 9'h000, 9'h050, 9'h000, 9'h140, 9'h000, 9'h000, 9'h002};
    logic [6:0]         wa   [6] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h08, 7'h31};
    logic [15:0]        wmsk [6] = '{16'h0015, 16'h01fa, 16'h0026, 16'h01fd, 16'h00bf, 16'h0002};

    prc_regs #(.PART_ID(ID), .DEVICE_REV(REV)) dut (.clk(clk), .nrst(nrst), .ce(ce), .cmd(cmd), .rsp(rsp),
        .die_hot_async(die_hot_async), .ctrl(ctrl), .sw_reset_pulse(sw_reset_pulse),
        .overtemp_alarm(overtemp_alarm));
    prc_host host (.clk(clk), .ce(ce), .cmd(cmd), .rsp(rsp));

    // free-running clock, 40 ns period
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic close_out;
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // every word and control output at its default
    task automatic t_defaults;
        for (int i = 0; i < 9; i++)
            chk(16'(ctrl.words[i]), 16'(dflt[i]));
        chk(16'(ctrl.ref_string_impedance_sel), 16'h0000);
        chk(16'(ctrl.amp_bias_enable), 16'h0000);
        chk(16'(ctrl.ref_softstart_enable), 16'h0000);
        chk(16'(ctrl.ref_fast_discharge), 16'h0000);
        chk(16'(ctrl.overtemp_protect_enable), 16'h0001);
    endtask

    // identifier read twice with one idle cycle between
    task automatic t_ident;
        host.rd(7'h00, rv);
        chk(rv, ID);
        host.rd(7'h00, rv);
        chk(rv, ID);
    endtask

    // all four impedance codes, bias toggled alongside
    task automatic t_impedance;
        logic [1:0] c;
        for (int k = 0; k < 4; k++)
        begin
            c = k[1:0];
            host.wr(7'h01, {5'h00, c[0], 1'b0, c});
            chk(16'(ctrl.ref_string_impedance_sel), 16'(c));
            chk(16'(ctrl.amp_bias_enable), 16'(c[0]));
            host.rd(7'h01, rv);
            chk(rv, {12'h000, c[0], REV});
        end
    endtask

    // soft start, then discharge only as part of power-down
    task automatic t_popmin;
        host.wr(7'h07, 9'h020);
        chk(16'(ctrl.ref_softstart_enable), 16'h0001);
        chk(16'(ctrl.ref_fast_discharge), 16'h0000);
        host.wr(7'h01, 9'h000);
        host.wr(7'h07, 9'h010);
        chk(16'(ctrl.ref_fast_discharge), 16'h0001);
        chk(16'(ctrl.ref_softstart_enable), 16'h0000);
        host.wr(7'h07, 9'h000);
    endtask

    // fixed-zero bits of six writable words and the all-zero word, frozen port and an unmapped read
    task automatic t_fixed;
        for (int i = 0; i < 6; i++)
        begin
            host.wr(wa[i], 9'h1ff);
            host.rd(wa[i], rv);
            chk(rv, wmsk[i]);
        end
        host.wr(7'h03, 9'h1ff);
        host.rd(7'h03, rv);
        chk(rv, 16'h0000);
        host.wr(7'h02, 9'h000, 1'b0);
        chk(16'(ctrl.words[1]), 16'h0015);
        host.rd(7'h0a, rv);
        chk(rv, 16'h0000);
    endtask

    // dirty several words, then write address zero
    task automatic t_softreset;
        host.wr(7'h01, 9'h0fb);
        host.wr(7'h31, 9'h000);
        chk(16'(ctrl.overtemp_protect_enable), 16'h0000);
        host.wr(7'h07, 9'h020);
        host.wr(7'h00, 9'h1ff);
        chk(16'(sw_reset_pulse), 16'h0001);
        t_defaults();
        @(posedge clk);
        #1;
        chk(16'(sw_reset_pulse), 16'h0000);
    endtask

    // hot die raises alarm when enabled, drops it when disabled
    task automatic t_overtemp;
        @(posedge clk);
        die_hot_async <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(16'(overtemp_alarm), 16'h0001);
        host.wr(7'h31, 9'h000);
        @(posedge clk);
        #1;
        chk(16'(overtemp_alarm), 16'h0000);
        host.wr(7'h31, 9'h002);
        @(posedge clk);
        #1;
        chk(16'(overtemp_alarm), 16'h0001);
        @(posedge clk);
        die_hot_async <= 1'b0;
    endtask

    // power-on reset in mid-run brings every default back
    task automatic t_por;
        host.wr(7'h06, 9'h000);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_defaults();
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        nrst          = 1'b0;
        die_hot_async = 1'b0;
        err_total     = 0;
        n_compared    = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_defaults();
        t_ident();
        t_impedance();
        t_popmin();
        t_fixed();
        t_softreset();
        t_overtemp();
        t_por();
        close_out();
    end

    // hang guard
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
